// ===== rtl/besl_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "besl_regs.svh"

module besl_core
  import besl_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // bridge events, one-cycle pulses
  input  wire logic                   ev_np_write_data_err,
  input  wire logic                   ev_posted_write_data_err,
  input  wire logic                   ev_read_cpl_data_err,
  input  wire logic                   ev_address_err,
  input  wire logic                   ev_master_abort_posted,
  input  wire logic                   ev_master_abort_nonposted,
  input  wire logic                   ev_target_abort,
  // forwarding context, levels
  input  wire logic                   fwd_posted_write,
  input  wire logic                   fwd_any,
  // configuration
  input  wire logic                   secondary_parity_response_enable,
  input  wire logic                   system_error_report_enable,
  input  wire logic                   error_reporting_enable,
  input  wire logic                   master_abort_error_mode,
  input  wire logic                   received_master_abort_mask,
  input  wire logic [`BESL_SEV_W-1:0] severity_fatal,
  // status, sticky, write-one-to-clear
  input  wire logic [`BESL_ST_W-1:0]  status_clear,
  output logic      [`BESL_ST_W-1:0]  status,
  // error message toward the upstream link
  input  wire logic                   msg_ready,
  output logic                        msg_valid,
  output logic                        msg_fatal,
  // PCI pins, active low; the parity pin output enable is active high
  input  wire logic                   pci_parity_error_pin_n,
  output logic                        pci_parity_error_pin_drive_n,
  output logic                        pci_parity_error_pin_oe,
  input  wire logic                   pci_system_error_pin_n
);

  function automatic logic cls_fatal(input logic [`BESL_SEV_W-1:0] sev, input int cls);
    return sev[cls];
  endfunction : cls_fatal

  besl_msg_if mi ();

  besl_msg_gen u_msg_gen (
    .clk (clk),
    .rst (rst),
    .mi  (mi)
  );

  // pin synchronisers; stage 1 only feeds stage 2
  logic perr_s1_q, perr_s2_q, perr_s3_q;
  logic serr_s1_q, serr_s2_q, serr_s3_q;
  logic perr_fall, serr_fall;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      perr_s1_q <= 1'b1;
      perr_s2_q <= 1'b1;
      perr_s3_q <= 1'b1;
      serr_s1_q <= 1'b1;
      serr_s2_q <= 1'b1;
      serr_s3_q <= 1'b1;
    end else begin
      perr_s1_q <= pci_parity_error_pin_n;
      perr_s2_q <= perr_s1_q;
      perr_s3_q <= perr_s2_q;
      serr_s1_q <= pci_system_error_pin_n;
      serr_s2_q <= serr_s1_q;
      serr_s3_q <= serr_s2_q;
    end
  end

  // edge only, so a pin held low logs one event
  assign perr_fall = !perr_s2_q && perr_s3_q;
  assign serr_fall = !serr_s2_q && serr_s3_q;

  // status accumulation
  besl_status_type st_q, st_d, st_set;
  logic det_data, det_ma, det_ta, ma_serr, req_f, req_n, gate_f, gate_n;

  always_comb begin
    st_set   = '0;
    det_data = ev_np_write_data_err || ev_posted_write_data_err || ev_read_cpl_data_err;
    det_ma   = ev_master_abort_posted || ev_master_abort_nonposted;
    det_ta   = ev_target_abort;
    if (perr_fall && fwd_posted_write) begin
      st_set[`BESL_UNC_PAR_SEEN] = 1'b1;
      st_set[`BESL_SEC_MDP]     = secondary_parity_response_enable;
    end
    if (serr_fall && fwd_any) begin
      st_set[`BESL_SEC_SERR]    = 1'b1;
      st_set[`BESL_UNC_SYS_SEEN] = 1'b1;
    end
    if (ev_np_write_data_err || ev_posted_write_data_err) begin
      st_set[`BESL_SEC_DPE]   = 1'b1;
      st_set[`BESL_UNC_DATA]  = 1'b1;
    end
    if (ev_posted_write_data_err && secondary_parity_response_enable) begin
      st_set[`BESL_SEC_MDP] = 1'b1;
    end
    if (ev_read_cpl_data_err) begin
      st_set[`BESL_UNC_PAR_SEEN] = 1'b1;
    end
    if (ev_address_err) begin
      st_set[`BESL_SEC_DPE]  = 1'b1;
      st_set[`BESL_SEC_STA]  = 1'b1;
      st_set[`BESL_UNC_UADD] = 1'b1;
    end
    if (ev_master_abort_posted) begin
      st_set[`BESL_SEC_RMA] = 1'b1;
      st_set[`BESL_UNC_RMA] = 1'b1;
    end
    if (det_ta) begin
      st_set[`BESL_SEC_RTA] = 1'b1;
      st_set[`BESL_UNC_RTA] = 1'b1;
    end
    // severity steers the detected bit per class
    st_set[`BESL_FATAL_DTD] =
      (det_data && cls_fatal(severity_fatal, `BESL_CLS_DATA)) ||
      (det_ma && cls_fatal(severity_fatal, `BESL_CLS_MA)) ||
      (det_ta && cls_fatal(severity_fatal, `BESL_CLS_TA));
    st_set[`BESL_NONFATAL_DTD] =
      (det_data && !cls_fatal(severity_fatal, `BESL_CLS_DATA)) ||
      (det_ma && !cls_fatal(severity_fatal, `BESL_CLS_MA)) ||
      (det_ta && !cls_fatal(severity_fatal, `BESL_CLS_TA));
    // posted master abort gates the primary error by mask and mode, not by message
    ma_serr = ev_master_abort_posted && system_error_report_enable &&
              (!received_master_abort_mask || master_abort_error_mode);
    st_set[`BESL_PRI_SERR] = ma_serr ||
      (mi.sent && mi.sent_gate && system_error_report_enable);
    // set wins over a clear in the same cycle
    st_d = (st_q & ~status_clear) | st_set;
  end

  // message requests; the read completion and posted master abort cases send a message but set no gate
  always_comb begin
    req_f  = 1'b0;
    req_n  = 1'b0;
    gate_f = 1'b0;
    gate_n = 1'b0;
    if (error_reporting_enable) begin
      req_f  = st_set[`BESL_FATAL_DTD] ||
               (ev_address_err && cls_fatal(severity_fatal, `BESL_CLS_ADDR));
      req_n  = st_set[`BESL_NONFATAL_DTD] ||
               (ev_address_err && !cls_fatal(severity_fatal, `BESL_CLS_ADDR));
      gate_f = req_f && (ev_np_write_data_err || ev_posted_write_data_err ||
               ev_address_err || ev_master_abort_nonposted || det_ta);
      gate_n = req_n && (ev_np_write_data_err || ev_posted_write_data_err ||
               ev_address_err || ev_master_abort_nonposted || det_ta);
    end
  end

  assign mi.req_fatal     = req_f;
  assign mi.req_nonfatal  = req_n;
  assign mi.gate_fatal    = gate_f;
  assign mi.gate_nonfatal = gate_n;
  assign mi.msg_ready     = msg_ready;
  assign msg_valid        = mi.msg_valid;
  assign msg_fatal        = mi.msg_fatal;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= `BESL_ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q;

  // parity pin driver: one clock low, one clock high, then release
  besl_pdrive_type pd_q, pd_d;
  logic pout_q, pout_d, poe_q, poe_d;

  always_comb begin
    pd_d = pd_q;
    case (pd_q)
      BESL_PD_IDLE: begin
        if (ev_posted_write_data_err && secondary_parity_response_enable) begin
          pd_d = BESL_PD_ASSERT;
        end
      end
      BESL_PD_ASSERT:  pd_d = BESL_PD_RESTORE;
      BESL_PD_RESTORE: pd_d = BESL_PD_IDLE;
      default:         pd_d = BESL_PD_IDLE;
    endcase
    pout_d = (pd_d != BESL_PD_ASSERT);
    poe_d  = (pd_d != BESL_PD_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_q   <= BESL_PD_IDLE;
      pout_q <= 1'b1;
      poe_q  <= 1'b0;
    end else begin
      pd_q   <= pd_d;
      pout_q <= pout_d;
      poe_q  <= poe_d;
    end
  end

  assign pci_parity_error_pin_drive_n = pout_q;
  assign pci_parity_error_pin_oe      = poe_q;

  // checks
  parity_seen_a: assert property (@(posedge clk) disable iff (rst)
    perr_fall && fwd_posted_write |=> st_q[`BESL_UNC_PAR_SEEN])
    else $error("parity seen bit not set");

  mdp_gate_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q[`BESL_SEC_MDP]) |-> $past(secondary_parity_response_enable))
    else $error("parity flag set with response disabled");

  serr_seen_a: assert property (@(posedge clk) disable iff (rst)
    serr_fall && fwd_any |=> st_q[`BESL_SEC_SERR] && st_q[`BESL_UNC_SYS_SEEN])
    else $error("system error seen bits not set");

  np_data_a: assert property (@(posedge clk) disable iff (rst)
    ev_np_write_data_err |=> st_q[`BESL_SEC_DPE] && st_q[`BESL_UNC_DATA] &&
      (st_q[`BESL_FATAL_DTD] || st_q[`BESL_NONFATAL_DTD]))
    else $error("non-posted data error not logged");

  perr_drive_a: assert property (@(posedge clk) disable iff (rst)
    ev_posted_write_data_err && secondary_parity_response_enable && pd_q == BESL_PD_IDLE
      |=> (poe_q && !pout_q) ##1 (poe_q && pout_q) ##1 !poe_q)
    else $error("parity pin drive sequence wrong");

  read_cpl_a: assert property (@(posedge clk) disable iff (rst)
    ev_read_cpl_data_err |=> st_q[`BESL_UNC_PAR_SEEN] &&
      (st_q[`BESL_FATAL_DTD] || st_q[`BESL_NONFATAL_DTD]))
    else $error("read completion error not logged");

  addr_err_a: assert property (@(posedge clk) disable iff (rst)
    ev_address_err |=> st_q[`BESL_SEC_DPE] && st_q[`BESL_SEC_STA] && st_q[`BESL_UNC_UADD])
    else $error("address error not logged");

  ma_posted_a: assert property (@(posedge clk) disable iff (rst)
    ev_master_abort_posted && system_error_report_enable &&
      (!received_master_abort_mask || master_abort_error_mode)
      |=> st_q[`BESL_PRI_SERR] && st_q[`BESL_SEC_RMA] && st_q[`BESL_UNC_RMA])
    else $error("posted master abort not logged");

  pri_serr_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q[`BESL_PRI_SERR]) |-> $past(system_error_report_enable))
    else $error("primary system error without enable");

  ta_both_a: assert property (@(posedge clk) disable iff (rst)
    ev_target_abort |=> st_q[`BESL_SEC_RTA] && st_q[`BESL_UNC_RTA])
    else $error("target abort bits not set");

  sev_fatal_a: assert property (@(posedge clk) disable iff (rst)
    ev_target_abort && severity_fatal[`BESL_CLS_TA] |=> st_q[`BESL_FATAL_DTD])
    else $error("fatal severity not honoured");

endmodule : besl_core

`default_nettype wire

// ===== include/besl_regs.svh
`ifndef BESL_REGS_SVH
`define BESL_REGS_SVH

// status vector layout
`define BESL_ST_W          15
`define BESL_SEC_MDP       0
`define BESL_SEC_DPE       1
`define BESL_SEC_STA       2
`define BESL_SEC_RMA       3
`define BESL_SEC_RTA       4
`define BESL_SEC_SERR      5
`define BESL_UNC_PAR_SEEN  6
`define BESL_UNC_SYS_SEEN  7
`define BESL_UNC_DATA      8
`define BESL_UNC_UADD      9
`define BESL_UNC_RMA       10
`define BESL_UNC_RTA       11
`define BESL_PRI_SERR      12
`define BESL_FATAL_DTD     13
`define BESL_NONFATAL_DTD  14
`define BESL_ST_RESET      15'h0000

// severity vector: one bit per error class, 1 = fatal
`define BESL_SEV_W         4
`define BESL_CLS_DATA      0
`define BESL_CLS_ADDR      1
`define BESL_CLS_MA        2
`define BESL_CLS_TA        3

`endif

// ===== include/besl_pkg.sv
`default_nettype none

package besl_pkg;

  typedef logic [14:0] besl_status_type;

  typedef enum logic [1:0] {
    BESL_PD_IDLE,
    BESL_PD_ASSERT,
    BESL_PD_RESTORE
  } besl_pdrive_type;

endpackage : besl_pkg

`default_nettype wire

// ===== include/besl_msg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface besl_msg_if;
  logic req_fatal;
  logic req_nonfatal;
  logic gate_fatal;
  logic gate_nonfatal;
  logic msg_ready;
  logic msg_valid;
  logic msg_fatal;
  logic sent;
  logic sent_gate;

  modport core (
    output req_fatal, req_nonfatal, gate_fatal, gate_nonfatal, msg_ready,
    input  msg_valid, msg_fatal, sent, sent_gate
  );

  modport gen (
    input  req_fatal, req_nonfatal, gate_fatal, gate_nonfatal, msg_ready,
    output msg_valid, msg_fatal, sent, sent_gate
  );
endinterface : besl_msg_if

`default_nettype wire

// ===== rtl/besl_msg_gen.sv
`timescale 1ns/1ps
`default_nettype none

module besl_msg_gen
  import besl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // message requests and upstream handshake
  besl_msg_if.gen  mi
);

  logic pend_f_q, pend_f_d;
  logic pend_n_q, pend_n_d;
  logic pgate_f_q, pgate_f_d;
  logic pgate_n_q, pgate_n_d;
  logic valid_q, valid_d;
  logic fatal_q, fatal_d;
  logic gate_q, gate_d;
  logic take_f, take_n;

  // fatal wins arbitration; a new request in the take cycle stays pending
  always_comb begin
    take_f    = !valid_q && pend_f_q;
    take_n    = !valid_q && !pend_f_q && pend_n_q;
    pend_f_d  = (pend_f_q && !take_f) || mi.req_fatal;
    pend_n_d  = (pend_n_q && !take_n) || mi.req_nonfatal;
    pgate_f_d = take_f ? mi.gate_fatal : ((pgate_f_q && pend_f_q) || mi.gate_fatal);
    pgate_n_d = take_n ? mi.gate_nonfatal : ((pgate_n_q && pend_n_q) || mi.gate_nonfatal);
    valid_d   = valid_q;
    fatal_d   = fatal_q;
    gate_d    = gate_q;
    if (valid_q && mi.msg_ready) begin
      valid_d = 1'b0;
    end else if (take_f || take_n) begin
      valid_d = 1'b1;
      fatal_d = take_f;
      gate_d  = take_f ? pgate_f_q : pgate_n_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_f_q  <= 1'b0;
      pend_n_q  <= 1'b0;
      pgate_f_q <= 1'b0;
      pgate_n_q <= 1'b0;
      valid_q   <= 1'b0;
      fatal_q   <= 1'b0;
      gate_q    <= 1'b0;
    end else begin
      pend_f_q  <= pend_f_d;
      pend_n_q  <= pend_n_d;
      pgate_f_q <= pgate_f_d;
      pgate_n_q <= pgate_n_d;
      valid_q   <= valid_d;
      fatal_q   <= fatal_d;
      gate_q    <= gate_d;
    end
  end

  assign mi.msg_valid = valid_q;
  assign mi.msg_fatal = fatal_q;
  assign mi.sent      = valid_q && mi.msg_ready;
  assign mi.sent_gate = gate_q;

endmodule : besl_msg_gen

`default_nettype wire

// ===== tb/besl_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module besl_far_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // upstream message acceptor
  input  wire logic msg_valid,
  input  wire logic msg_fatal,
  input  wire logic slow,
  output logic      msg_ready,
  output int        n_fatal,
  output int        n_nonfatal,
  // pci pins, both pulled up
  input  wire logic perr_oe,
  input  wire logic perr_out_n,
  input  wire logic agent_perr,
  input  wire logic agent_serr,
  output logic      perr_wire_n,
  output logic      serr_wire_n
);
  logic [1:0] phase_q;

  // slow mode takes one cycle in four, so pending messages must wait
  assign msg_ready   = !slow || (phase_q == 2'h3);
  assign perr_wire_n = !(perr_oe && !perr_out_n) && !agent_perr;
  assign serr_wire_n = !agent_serr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q    <= 2'h0;
      n_fatal    <= 0;
      n_nonfatal <= 0;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (msg_valid && msg_ready && msg_fatal) n_fatal <= n_fatal + 1;
      if (msg_valid && msg_ready && !msg_fatal) n_nonfatal <= n_nonfatal + 1;
    end
  end
endmodule : besl_far_model

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "besl_regs.svh"

module testbench
  import besl_pkg::*;
;
  logic clk, rst, fwd_pw, fwd_any, slow, ag_perr, ag_serr, oe, out_n, perr_n, serr_n;
  logic msg_ready, msg_valid, msg_fatal;
  logic [6:0] ev;
  logic [8:0] cfg;
  besl_status_type clr, status;
  int n_fatal, n_nonfatal, mismatches, comparisons;
  logic [31:0] seed;

  besl_core i_dut (
    .clk(clk), .rst(rst),
    .ev_np_write_data_err(ev[0]), .ev_posted_write_data_err(ev[1]),
    .ev_read_cpl_data_err(ev[2]), .ev_address_err(ev[3]),
    .ev_master_abort_posted(ev[4]), .ev_master_abort_nonposted(ev[5]),
    .ev_target_abort(ev[6]), .fwd_posted_write(fwd_pw), .fwd_any(fwd_any),
    .secondary_parity_response_enable(cfg[0]), .system_error_report_enable(cfg[1]),
    .error_reporting_enable(cfg[2]), .master_abort_error_mode(cfg[3]),
    .received_master_abort_mask(cfg[4]), .severity_fatal(cfg[8:5]),
    .status_clear(clr), .status(status), .msg_ready(msg_ready),
    .msg_valid(msg_valid), .msg_fatal(msg_fatal),
    .pci_parity_error_pin_n(perr_n), .pci_parity_error_pin_drive_n(out_n),
    .pci_parity_error_pin_oe(oe), .pci_system_error_pin_n(serr_n));

  besl_far_model i_far (
    .clk(clk), .rst(rst), .msg_valid(msg_valid), .msg_fatal(msg_fatal), .slow(slow),
    .msg_ready(msg_ready), .n_fatal(n_fatal), .n_nonfatal(n_nonfatal),
    .perr_oe(oe), .perr_out_n(out_n), .agent_perr(ag_perr), .agent_serr(ag_serr),
    .perr_wire_n(perr_n), .serr_wire_n(serr_n));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // event kinds 0..6 follow ev bits, 7 parity pin, 8 system pin
  function automatic int cls_of(input int k);
    if (k == 3) return `BESL_CLS_ADDR;
    if (k == 4 || k == 5) return `BESL_CLS_MA;
    if (k == 6) return `BESL_CLS_TA;
    return `BESL_CLS_DATA;
  endfunction : cls_of

  function automatic besl_status_type exp_st(input int k, input logic [8:0] c);
    besl_status_type s;
    logic gate;
    s = `BESL_ST_RESET;
    gate = c[2] & c[1];
    case (k)
      0, 1: begin
        s[`BESL_SEC_DPE] = 1'b1;
        s[`BESL_UNC_DATA] = 1'b1;
        s[`BESL_SEC_MDP] = (k == 1) & c[0];
        s[`BESL_PRI_SERR] = gate;
      end
      2: s[`BESL_UNC_PAR_SEEN] = 1'b1;
      3: begin
        s[`BESL_SEC_DPE] = 1'b1;
        s[`BESL_SEC_STA] = 1'b1;
        s[`BESL_UNC_UADD] = 1'b1;
        s[`BESL_PRI_SERR] = gate;
      end
      4: begin
        s[`BESL_SEC_RMA] = 1'b1;
        s[`BESL_UNC_RMA] = 1'b1;
        s[`BESL_PRI_SERR] = c[1] & (!c[4] | c[3]);
      end
      5: s[`BESL_PRI_SERR] = gate;
      6: begin
        s[`BESL_SEC_RTA] = 1'b1;
        s[`BESL_UNC_RTA] = 1'b1;
        s[`BESL_PRI_SERR] = gate;
      end
      7: begin
        s[`BESL_UNC_PAR_SEEN] = 1'b1;
        s[`BESL_SEC_MDP] = c[0];
      end
      default: begin
        s[`BESL_SEC_SERR] = 1'b1;
        s[`BESL_UNC_SYS_SEEN] = 1'b1;
      end
    endcase
    if (k < 7 && k != 3) s[c[5 + cls_of(k)] ? `BESL_FATAL_DTD : `BESL_NONFATAL_DTD] = 1'b1;
    return s;
  endfunction : exp_st

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // clr_ev: clear everything on the event edge, where the new set must win
  task automatic trial(input int k, input logic [8:0] c, input logic clr_ev, input logic sl);
    int nf, nn, ocnt, lcnt;
    logic fat, rep;
    fat = c[5 + cls_of(k)];
    rep = (k < 7) && c[2];
    nf = n_fatal;
    nn = n_nonfatal;
    ocnt = 0;
    lcnt = 0;
    @(posedge clk);
    cfg <= c;
    slow <= sl;
    fwd_pw <= (k == 7);
    fwd_any <= (k >= 7);
    @(posedge clk);
    if (k < 7) ev <= 7'h01 << k;
    ag_perr <= (k == 7);
    ag_serr <= (k == 8);
    clr <= clr_ev ? 15'h7FFF : 15'h0000;
    @(posedge clk);
    ev <= 7'h00;
    clr <= 15'h0000;
    repeat (24) begin
      #1;
      ocnt += oe;
      lcnt += oe & !out_n;
      @(posedge clk);
    end
    chk("status", exp_st(k, c), status);
    chk("fatal msgs", nf + (rep & fat), n_fatal);
    chk("nonfatal msgs", nn + (rep & !fat), n_nonfatal);
    chk("perr drive cycles", (k == 1 && c[0]) ? 2 : 0, ocnt);
    chk("perr low cycles", (k == 1 && c[0]) ? 1 : 0, lcnt);
    clr <= 15'h7FFF;
    @(posedge clk);
    clr <= 15'h0000;
    repeat (6) @(posedge clk);
    // pins still held low here: a held pin must not log twice
    chk("status after clear", 32'h0, status);
    ag_perr <= 1'b0;
    ag_serr <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : trial

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 20000);
    mismatches++;
    stop_test();
  end

  initial begin
    logic [31:0] r;
    seed = 32'h0000003E;
    mismatches = 0;
    comparisons = 0;
    rst = 1'b1;
    {fwd_pw, fwd_any, slow, ag_perr, ag_serr} = 5'h00;
    ev = 7'h00;
    cfg = 9'h000;
    clr = 15'h0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset outputs", 32'h1, {status, msg_valid, oe, out_n});
    for (int k = 0; k < 9; k++) begin
      trial(k, 9'h1FF, 1'b0, 1'b0);
      trial(k, 9'h000, 1'b1, 1'b1);
    end
    repeat (70) begin
      r = xs();
      trial(int'(r[31:16] % 9), r[8:0], r[9], r[10]);
    end
    stop_test();
  end
endmodule : testbench

`default_nettype wire
